// *** rtl/ett_timer.sv ***
// Eight-bit timer/counter with shared prescaler and register port
`timescale 1ns/1ps
`default_nettype none

module ett_timer #(
   parameter int unsigned CNT_W = 8,
   parameter int unsigned PRE_W = 8
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   // Register port
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_en_i,
   input  wire logic       rd_en_i,
   output var  logic [7:0] rdata_o,
   // Count pin, two-way
   input  wire logic       external_count_pin_i,
   output var  logic       external_count_pin_o,
   output var  logic       external_count_pin_oe_o,
   // Comparator output
   input  wire logic       comparator_one_result_i,
   // Watchdog tick through the prescaler
   input  wire logic       wdt_tick_i,
   output var  logic       wdt_tick_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Parameter check
   if (CNT_W != 8 || PRE_W != 8) begin : g_bad_width
      $error("ett_timer: counter and prescaler must be 8 bits");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic [PRE_W-1:0] presc;
      logic [5:0]       option;
      logic [6:0]       cmp_ctrl;
      logic [1:0]       hold;
      logic [2:0]       pin_sync;
      logic [2:0]       cmp_sync;
      logic [7:0]       rdata;
      logic             pin_out;
      logic             pin_oe;
      logic             wdt_out;
   } ett_state_s;

   ett_state_s          state_reg;
   ett_state_s          state_next;
   ett_pkg::ett_mode_e  mode;
   logic                wr_count;
   logic                src_tick;
   logic                edge_pin;
   logic                edge_cmp;
   logic                presc_tick;
   logic                presc_hit;
   logic                count_inc;
   logic                to_wdt;
   logic [PRE_W-1:0]    mask;

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      state_next = state_reg;
      wr_count   = wr_en_i && addr_i == ett_pkg::COUNT_OFS;
      to_wdt     = state_reg.option[ett_pkg::OPT_ASSIGN_BIT];
      src_tick   = 1'b0;

      if (!state_reg.option[ett_pkg::OPT_SRC_BIT]) begin
         mode = ett_pkg::MODE_TIMER;
      end else if (!state_reg.cmp_ctrl[ett_pkg::CMP_ROUTE_BIT]) begin
         mode = ett_pkg::MODE_CMP_INT;
      end else if (state_reg.cmp_ctrl[ett_pkg::CMP_OEN_BIT]) begin
         mode = ett_pkg::MODE_PIN;
      end else begin
         mode = ett_pkg::MODE_CMP_LOOP;
      end

      // two-stage synchronisers, edges from later stages
      // Stage one feeds stage two only, to keep metastability out
      state_next.pin_sync = {state_reg.pin_sync[1:0], external_count_pin_i};
      state_next.cmp_sync = {state_reg.cmp_sync[1:0], comparator_one_result_i};
      // rising when clear, falling when set
      if (state_reg.option[ett_pkg::OPT_EDGE_BIT]) begin
         edge_pin = !state_reg.pin_sync[1] && state_reg.pin_sync[2];
         edge_cmp = !state_reg.cmp_sync[1] && state_reg.cmp_sync[2];
      end else begin
         edge_pin = state_reg.pin_sync[1] && !state_reg.pin_sync[2];
         edge_cmp = state_reg.cmp_sync[1] && !state_reg.cmp_sync[2];
      end

      unique case (mode)
         ett_pkg::MODE_TIMER:   src_tick = 1'b1;
         ett_pkg::MODE_CMP_INT: src_tick = edge_cmp;
         ett_pkg::MODE_PIN:     src_tick = edge_pin;
         ett_pkg::MODE_CMP_LOOP: src_tick = edge_pin;
      endcase

      // comparator driven onto pin in loop-back mode
      state_next.pin_out = comparator_one_result_i;
      state_next.pin_oe  = mode == ett_pkg::MODE_CMP_LOOP;

      // ratio 2^(select+1) from low bits all ones
      mask = ett_pkg::PRE_ONES >> (ett_pkg::PS_MAX -
             state_reg.option[ett_pkg::OPT_PS_MSB:ett_pkg::OPT_PS_LSB]);
      presc_hit = (state_reg.presc & mask) == mask;
      // prescaler fed by timer source or watchdog, never both
      presc_tick = to_wdt ? wdt_tick_i : src_tick;
      if (presc_tick) begin
         state_next.presc = state_reg.presc + PRE_W'(1);
      end
      state_next.wdt_out = to_wdt && wdt_tick_i && presc_hit;
      count_inc = to_wdt ? src_tick : (src_tick && presc_hit);

      // write reloads and holds off increments for two cycles
      if (wr_count) begin
         state_next.count = wdata_i[CNT_W-1:0];
         state_next.hold  = ett_pkg::WRITE_HOLD;
      end else if (state_reg.hold != 2'h0) begin
         state_next.hold = state_reg.hold - 2'h1;
      end else if (count_inc) begin
         // wraps from all ones to zero
         state_next.count = state_reg.count + CNT_W'(1);
      end

      // Register writes; unmapped addresses ignored
      if (wr_en_i) begin
         unique case (addr_i)
            ett_pkg::OPTION_OFS: state_next.option = wdata_i[5:0];
            ett_pkg::CMP_SMALL_OFS, ett_pkg::CMP_LARGE_OFS: begin
               state_next.cmp_ctrl = wdata_i[6:0];
            end
            default: ;
         endcase
      end

      state_next.rdata = 8'h00;
      if (rd_en_i) begin
         unique case (addr_i)
            ett_pkg::COUNT_OFS:  state_next.rdata = 8'(state_reg.count);
            ett_pkg::OPTION_OFS: state_next.rdata = {2'h0, state_reg.option};
            ett_pkg::CMP_SMALL_OFS, ett_pkg::CMP_LARGE_OFS: begin
               state_next.rdata = {state_reg.cmp_sync[1], state_reg.cmp_ctrl};
            end
            default: state_next.rdata = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg          <= '0;
         state_reg.option   <= ett_pkg::OPTION_RESET;
         state_reg.cmp_ctrl <= ett_pkg::CMP_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata_o                 = state_reg.rdata;
   assign external_count_pin_o    = state_reg.pin_out;
   assign external_count_pin_oe_o = state_reg.pin_oe;
   assign wdt_tick_o              = state_reg.wdt_out;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   read_count_a: assert property (
      rd_en_i && addr_i == ett_pkg::COUNT_OFS |=> rdata_o == 8'($past(state_reg.count)))
      else $error("count read returned wrong value");

   timer_step_a: assert property (
      mode == ett_pkg::MODE_TIMER && to_wdt && state_reg.hold == 2'h0 && !wr_count
      |=> state_reg.count == $past(state_reg.count) + CNT_W'(1))
      else $error("timer mode missed an increment");

   write_hold_a: assert property (
      (wr_count ##1 !wr_count [*2]) |=> state_reg.count == $past(state_reg.count, 2))
      else $error("counter moved within two cycles of a write");

   pin_mode_a: assert property (
      mode == ett_pkg::MODE_PIN && to_wdt && state_reg.hold == 2'h0 && !wr_count
      && !edge_pin |=> $stable(state_reg.count))
      else $error("pin mode counted without an edge");

   pin_idle_a: assert property (
      mode != ett_pkg::MODE_CMP_LOOP |=> !external_count_pin_oe_o)
      else $error("pin driven outside loop-back mode");

   rise_edge_a: assert property (
      mode == ett_pkg::MODE_PIN && !state_reg.option[ett_pkg::OPT_EDGE_BIT] && to_wdt
      && state_reg.hold == 2'h0 && !wr_count && state_reg.pin_sync[1]
      && !state_reg.pin_sync[2] |=> state_reg.count == $past(state_reg.count) + CNT_W'(1))
      else $error("rising edge not counted");

   cmp_internal_a: assert property (
      mode == ett_pkg::MODE_CMP_INT && to_wdt && state_reg.hold == 2'h0 && !wr_count
      && edge_cmp |=> state_reg.count == $past(state_reg.count) + CNT_W'(1))
      else $error("internal comparator edge not counted");

   loop_drive_a: assert property (
      mode == ett_pkg::MODE_CMP_LOOP |=> external_count_pin_oe_o
      && external_count_pin_o == $past(comparator_one_result_i))
      else $error("comparator not driven onto pin");

   wdt_share_a: assert property (
      !to_wdt |=> !wdt_tick_o)
      else $error("watchdog tick while prescaler owned by timer");

   ratio_two_a: assert property (
      mode == ett_pkg::MODE_TIMER && !to_wdt && state_reg.hold == 2'h0 && !wr_count
      && state_reg.option[ett_pkg::OPT_PS_MSB:ett_pkg::OPT_PS_LSB] == 3'h0
      && !state_reg.presc[0] |=> $stable(state_reg.count))
      else $error("1:2 ratio counted on even prescaler phase");

   wrap_zero_a: assert property (
      state_reg.count == '1 && count_inc && state_reg.hold == 2'h0 && !wr_count
      |=> state_reg.count == '0)
      else $error("counter did not wrap to zero");

   ////////////////////////////////////////////////////////////////////////////////
   // Register port checks

   read_idle_a: assert property (
      !rd_en_i |=> rdata_o == 8'h00)
      else $error("read data not zero outside a read");

   read_option_a: assert property (
      rd_en_i && addr_i == ett_pkg::OPTION_OFS
      |=> rdata_o == {2'h0, $past(state_reg.option)})
      else $error("option read returned wrong value");

   read_hidden_a: assert property (
      rd_en_i && addr_i != ett_pkg::COUNT_OFS && addr_i != ett_pkg::OPTION_OFS
      && addr_i != ett_pkg::CMP_SMALL_OFS && addr_i != ett_pkg::CMP_LARGE_OFS
      |=> rdata_o == 8'h00)
      else $error("unmapped read returned data");

   cmp_read_a: assert property (
      rd_en_i && addr_i == ett_pkg::CMP_SMALL_OFS
      |=> rdata_o == {$past(state_reg.cmp_sync[1]), $past(state_reg.cmp_ctrl)})
      else $error("comparator control read returned wrong value");

   count_load_a: assert property (
      wr_count |=> state_reg.count == $past(wdata_i[CNT_W-1:0]))
      else $error("count write did not land");

   option_load_a: assert property (
      wr_en_i && addr_i == ett_pkg::OPTION_OFS
      |=> state_reg.option == $past(wdata_i[5:0]))
      else $error("option write did not land");

   cmp_load_a: assert property (
      wr_en_i && (addr_i == ett_pkg::CMP_SMALL_OFS || addr_i == ett_pkg::CMP_LARGE_OFS)
      |=> state_reg.cmp_ctrl == $past(wdata_i[6:0]))
      else $error("comparator control write did not land");

   hold_load_a: assert property (
      wr_count |=> state_reg.hold == ett_pkg::WRITE_HOLD)
      else $error("count write did not start hold");

   hold_block_a: assert property (
      state_reg.hold != 2'h0 && !wr_count |=> $stable(state_reg.count))
      else $error("counter moved during hold");

   ////////////////////////////////////////////////////////////////////////////////
   // Count source checks

   fall_edge_a: assert property (
      mode == ett_pkg::MODE_PIN && state_reg.option[ett_pkg::OPT_EDGE_BIT] && to_wdt
      && state_reg.hold == 2'h0 && !wr_count && !state_reg.pin_sync[1]
      && state_reg.pin_sync[2] |=> state_reg.count == $past(state_reg.count) + CNT_W'(1))
      else $error("falling edge not counted");

   cmp_quiet_a: assert property (
      mode == ett_pkg::MODE_CMP_INT && to_wdt && state_reg.hold == 2'h0 && !wr_count
      && !edge_cmp |=> $stable(state_reg.count))
      else $error("internal comparator mode counted without an edge");

   loop_count_a: assert property (
      mode == ett_pkg::MODE_CMP_LOOP && to_wdt && state_reg.hold == 2'h0 && !wr_count
      && edge_pin |=> state_reg.count == $past(state_reg.count) + CNT_W'(1))
      else $error("looped-back comparator edge not counted");

   ////////////////////////////////////////////////////////////////////////////////
   // Prescaler checks

   presc_step_a: assert property (
      presc_tick |=> state_reg.presc == $past(state_reg.presc) + PRE_W'(1))
      else $error("prescaler missed a tick");

   presc_owner_a: assert property (
      to_wdt && !wdt_tick_i |=> $stable(state_reg.presc))
      else $error("timer source moved watchdog prescaler");

   ratio_gate_a: assert property (
      !to_wdt && state_reg.hold == 2'h0 && !wr_count && !presc_hit
      |=> $stable(state_reg.count))
      else $error("counter stepped before prescaler ratio");

   wdt_ratio_a: assert property (
      to_wdt && wdt_tick_i && presc_hit |=> wdt_tick_o)
      else $error("prescaled watchdog tick missing");

endmodule

`default_nettype wire

// *** shared/ett_pkg.sv ***
// Constants and types shared by the eight-bit timer/counter
// How it works
// - Counter is 8 bits, read and write
// - Source select clear: count cycles, every cycle with prescaler on watchdog
// - Counter write blocks increments two cycles
// - Select, route, enable set: count pin edges
// - Edge select clear rising, set falling
// - Route clear: comparator drives count internally
// - Enable clear: comparator drives pin, looped back
// - Prescaler serves timer or watchdog, not both
// - Prescaler count hidden from software
// - Ratios 1:2 to 1:256 in powers of two
// - Prescaler is 8-bit, ratio from option bits
`default_nettype none

package ett_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] COUNT_OFS     = 8'h01;
   localparam logic [7:0] OPTION_OFS    = 8'h02;
   localparam logic [7:0] CMP_SMALL_OFS = 8'h07;
   localparam logic [7:0] CMP_LARGE_OFS = 8'h08;

   ////////////////////////////////////////////////////////////////////////////////
   // Option field positions and reset
   localparam int unsigned OPT_SRC_BIT    = 5;
   localparam int unsigned OPT_EDGE_BIT   = 4;
   localparam int unsigned OPT_ASSIGN_BIT = 3;
   localparam int unsigned OPT_PS_MSB     = 2;
   localparam int unsigned OPT_PS_LSB     = 0;
   localparam logic [5:0]  OPTION_RESET   = 6'h3f;

   ////////////////////////////////////////////////////////////////////////////////
   // Comparator control field positions and reset
   localparam int unsigned CMP_RESULT_BIT = 7;
   localparam int unsigned CMP_OEN_BIT    = 6;
   localparam int unsigned CMP_ROUTE_BIT  = 4;
   localparam logic [6:0]  CMP_RESET      = 7'h7f;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing and prescaler
   localparam logic [1:0] WRITE_HOLD = 2'h2;
   localparam logic [2:0] PS_MAX     = 3'h7;
   localparam logic [7:0] PRE_ONES   = 8'hff;

   // Count source in use
   typedef enum logic [3:0] {
      MODE_TIMER    = 4'h1,
      MODE_CMP_INT  = 4'h2,
      MODE_PIN      = 4'h4,
      MODE_CMP_LOOP = 4'h8
   } ett_mode_e;

endpackage

`default_nettype wire

// *** dv/ett_pin_src.sv ***
// Count-pin and comparator source model
`timescale 1ns/1ps
`default_nettype none

module ett_pin_src (
   // Clock
   input  wire logic clk_i,
   // Design pin drive
   input  wire logic drv_i,
   input  wire logic drv_oe_i,
   // Resolved pin and comparator
   output var  logic pin_o,
   output var  logic cmp_o
);
   logic ext_lvl = 1'b0;

   initial cmp_o = 1'b0;

   // Design owns the pin while it drives
   assign pin_o = drv_oe_i ? drv_i : ext_lvl;

   task automatic toggle(input logic on_cmp, input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge clk_i);
         if (on_cmp) begin
            cmp_o <= ~cmp_o;
         end
         else begin
            ext_lvl <= ~ext_lvl;
         end
         repeat (2) @(posedge clk_i);
      end
      repeat (5) @(posedge clk_i);
   endtask
endmodule

`default_nettype wire

// *** dv/tb_ett_timer.sv ***
// Self-checking bench for the eight-bit timer/counter
`timescale 1ns/1ps
`default_nettype none

module tb_ett_timer;
   localparam logic [7:0] CNT = ett_pkg::COUNT_OFS;
   localparam logic [7:0] OPT = ett_pkg::OPTION_OFS;
   localparam logic [7:0] CMS = ett_pkg::CMP_SMALL_OFS;
   localparam logic [7:0] CML = ett_pkg::CMP_LARGE_OFS;

   logic       clk_i      = 1'b0;
   logic       reset_n_i  = 1'b0;
   logic [7:0] addr_i     = 8'h00;
   logic [7:0] wdata_i    = 8'h00;
   logic       wr_en_i    = 1'b0;
   logic       rd_en_i    = 1'b0;
   logic       wdt_tick_i = 1'b0;
   logic [7:0] rdata_o;
   logic       pin_o, pin_oe_o, pin_w, cmp_w, wdt_o;
   logic [7:0] a, b;
   int         miscompares = 0;
   int         compares    = 0;
   int         wdt_seen    = 0;

   always #4 clk_i = ~clk_i;

   always @(posedge clk_i) begin
      if (wdt_o === 1'b1) wdt_seen <= wdt_seen + 1;
   end

   ett_timer ett_timer_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o),
      .external_count_pin_i(pin_w), .external_count_pin_o(pin_o),
      .external_count_pin_oe_o(pin_oe_o), .comparator_one_result_i(cmp_w),
      .wdt_tick_i(wdt_tick_i), .wdt_tick_o(wdt_o));

   ett_pin_src ett_pin_src_i (.clk_i(clk_i), .drv_i(pin_o), .drv_oe_i(pin_oe_o),
      .pin_o(pin_w), .cmp_o(cmp_w));

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk_i);
      wr_en_i <= 1'b1;
      addr_i  <= ad;
      wdata_i <= d;
      @(posedge clk_i);
      wr_en_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] ad, output logic [7:0] d);
      @(posedge clk_i);
      rd_en_i <= 1'b1;
      addr_i  <= ad;
      @(posedge clk_i);
      rd_en_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e);
      rd(ad, a);
      chk($sformatf("reg %h", ad), e, a);
   endtask

   // Edges seen in n toggles from a start level
   function automatic logic [7:0] edges(input logic lvl, input int n, input logic fall);
      return 8'((lvl == fall) ? (n + 1) / 2 : n / 2);
   endfunction

   task automatic cnt_edges(input logic on_cmp, input int n, input logic fall,
                            input logic live);
      logic lvl;
      lvl = on_cmp ? ett_pin_src_i.cmp_o : ett_pin_src_i.ext_lvl;
      rd(CNT, a);
      ett_pin_src_i.toggle(on_cmp, n);
      rd(CNT, b);
      chk("edge count", live ? edges(lvl, n, fall) : 8'h00, b - a);
   endtask

   task automatic chk_oe(input logic e);
      repeat (2) @(posedge clk_i);
      #1;
      chk("pin enable", {7'h00, e}, {7'h00, pin_oe_o});
   endtask

   task automatic tally_and_finish();
      if (miscompares == 0 && compares > 0) begin
         $display("TEST PASSED");
      end
      else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      #400us;
      miscompares++;
      tally_and_finish();
   end

   initial begin
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      rd_chk(CNT, 8'h00);
      rd_chk(OPT, 8'h3f);
      rd_chk(CMS, 8'h7f);
      wr(8'h05, 8'ha5);
      rd_chk(8'h05, 8'h00);
      wr(OPT, 8'hff);
      rd_chk(OPT, 8'h3f);
      wr(OPT, 8'h08);
      wr(CNT, 8'hfe);
      rd_chk(CNT, 8'hfe);
      rd_chk(CNT, 8'hff);
      rd_chk(CNT, 8'h01);
      for (int s = 0; s < 8; s++) begin
         wr(OPT, 8'(s));
         rd(CNT, a);
         repeat ((4 << s) - 2) @(posedge clk_i);
         rd(CNT, b);
         chk("prescaled steps", 8'h02, b - a);
      end
      wr(OPT, 8'h09);
      b = 8'(wdt_seen);
      repeat (8) begin
         @(posedge clk_i) wdt_tick_i <= 1'b1;
         @(posedge clk_i) wdt_tick_i <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      chk("watchdog ticks", 8'h02, 8'(wdt_seen) - b);
      wr(OPT, 8'h28);
      chk_oe(1'b0);
      cnt_edges(1'b0, 3, 1'b0, 1'b1);
      cnt_edges(1'b1, 2, 1'b0, 1'b0);
      wr(OPT, 8'h38);
      cnt_edges(1'b0, 3, 1'b1, 1'b1);
      wr(CMS, 8'h6f);
      cnt_edges(1'b1, 3, 1'b1, 1'b1);
      cnt_edges(1'b0, 2, 1'b1, 1'b0);
      wr(CML, 8'h2f);
      cnt_edges(1'b1, 3, 1'b1, 1'b1);
      wr(OPT, 8'h28);
      wr(CMS, 8'h3f);
      chk_oe(1'b1);
      cnt_edges(1'b1, 3, 1'b0, 1'b1);
      cnt_edges(1'b0, 2, 1'b0, 1'b0);
      chk("pin drive", {7'h00, cmp_w}, {7'h00, pin_o});
      rd_chk(CML, {cmp_w, 7'h3f});
      tally_and_finish();
   end
endmodule

`default_nettype wire
